// ==== hdl/link_sequencer.sv ====
// power-up and link start-up sequencer with its two link registers
// assumes the phy reports beacon, handshake and calibration on CLK
`timescale 1ns/10ps
module link_sequencer
    import link_seq_pkg::*;
#(
    parameter int OSC_START_CYCLES = OSC_START_CYC,
    parameter int LOCK_LIMIT_CYCLES = LOCK_LIMIT_CYC
)
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic POWER_DOWN_N_PIN,
    input wire logic SUPPLY_OK,
    input wire logic [1:0] STRAP,
    input wire reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire phy_stat_t PHY_STAT,
    output logic OSC_EN,
    output logic TERM_CAL,
    output logic [1:0] BEACON,
    output logic [1:0] PHY_EN,
    output logic HANDSHAKE_REQ,
    output logic CANCEL_CAL,
    output logic EQ_CAL,
    output logic CHAN_EN,
    output logic LOCK,
    output logic [1:0] TX_RATE,
    output logic [1:0] RX_RATE
);
    // ----------------------------------------
    // pins and timer
    // ----------------------------------------
    seq_t cur;
    seq_t next;
    logic [3:0] pins;
    logic pwr_ok;
    logic tdone;
    logic tstart;
    logic [CNT_W-1:0] tload;
    logic in_link;
    logic access;
    logic wr_topo;
    logic [1:0] seen;
    logic [1:0] want;

    pin_sync u_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .pin({STRAP, SUPPLY_OK, POWER_DOWN_N_PIN}),
        .q(pins)
    );

    step_timer u_timer (
        .clk(CLK),
        .rst_b(RST_B),
        .start(tstart),
        .load(tload),
        .done(tdone)
    );

    assign pwr_ok = pins[0] & pins[1];
    assign seen = PHY_STAT.beacon_seen;
    assign in_link = (cur.st > S_LINK_RST);
    assign access = (cur.st >= S_LINK_RST);
    assign wr_topo = access && REG_REQ.wr && (REG_REQ.addr == TOPO_ADDR);

    // ports a beacon must answer on before the handshake
    always_comb
    begin
        want = cur.port_sel;
        if (cur.act_auto)
        begin
            want = (seen[0]) ? PORT_A : PORT_B;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        next = cur;
        next.rvalid = 1'b0;
        tstart = 1'b0;
        tload = '0;
        case (cur.st)
            S_OFF:
            begin
                if (pwr_ok)
                begin
                    next.st = S_OSC;
                    tstart = 1'b1;
                    tload = CNT_W'(OSC_START_CYCLES);
                end
            end
            S_OSC:
            begin
                if (tdone)
                begin
                    next.st = S_TERM;
                    tstart = 1'b1;
                    tload = CNT_W'(TERM_CAL_CYC);
                end
            end
            S_TERM:
            begin
                if (tdone)
                begin
                    next.st = S_STRAP;
                end
            end
            S_STRAP:
            begin
                // straps only set the forward speed; the rest keep reset
                next.speed[TX_RATE_LSB+:2] = pins[3:2];
                next.st = S_LINK_RST;
            end
            S_LINK_RST:
            begin
                // settings take effect only here, never mid-link
                next.act_tx = cur.speed[TX_RATE_LSB+:2];
                next.act_rx = cur.speed[RX_RATE_LSB+:2];
                next.act_auto = cur.topo[AUTO_BIT];
                next.topo[RESTART_BIT] = 1'b0;
                next.deadline = CNT_W'(LOCK_LIMIT_CYCLES);
                if (cur.topo[AUTO_BIT])
                begin
                    next.port_sel = PORT_BOTH;
                end
                else
                begin
                    case (cur.topo[CFG_LSB+:2])
                        TOPO_A: next.port_sel = PORT_A;
                        TOPO_B: next.port_sel = PORT_B;
                        default: next.port_sel = PORT_BOTH;
                    endcase
                end
                next.st = S_BEACON;
            end
            S_BEACON:
            begin
                if ((cur.act_auto && seen != 2'h0) ||
                    (!cur.act_auto && (seen & want) == want))
                begin
                    next.port_sel = want;
                    next.st = S_HS;
                end
            end
            S_HS:
            begin
                if (PHY_STAT.hs_done)
                begin
                    next.st = S_CANCEL;
                end
            end
            S_CANCEL:
            begin
                if (PHY_STAT.cancel_done)
                begin
                    next.st = S_EQ;
                end
            end
            S_EQ:
            begin
                if (PHY_STAT.eq_done)
                begin
                    next.st = S_LOCK;
                end
            end
            S_LOCK:
            begin
                // a lost port relinks via S_LINK_RST, which reloads the topology register
                if ((seen & cur.port_sel) != cur.port_sel)
                begin
                    next.st = S_LINK_RST;
                end
            end
            default:
            begin
                next.st = S_OFF;
            end
        endcase

        // no lock within the limit: start the link over
        if (in_link && cur.st != S_LOCK)
        begin
            if (cur.deadline == '0)
            begin
                next.st = S_LINK_RST;
            end
            else
            begin
                next.deadline = cur.deadline - 1'b1;
            end
        end

        // register port; a write of the restart bit wins over its clear
        if (access && REG_REQ.wr)
        begin
            case (REG_REQ.addr)
                SPEED_ADDR: next.speed = REG_REQ.wdata;
                TOPO_ADDR: next.topo = REG_REQ.wdata;
                default: next.topo = next.topo;
            endcase
        end
        if (REG_REQ.rd)
        begin
            next.rvalid = 1'b1;
            next.rdata = 8'h00;
            if (access)
            begin
                case (REG_REQ.addr)
                    SPEED_ADDR: next.rdata = cur.speed;
                    TOPO_ADDR: next.rdata = cur.topo;
                    STATUS_ADDR:
                    begin
                        next.rdata[LOCK_BIT] = cur.lock;
                        next.rdata[STEP_LSB+:4] = cur.st;
                    end
                    default: next.rdata = 8'h00;
                endcase
            end
        end
        if (wr_topo && REG_REQ.wdata[RESTART_BIT])
        begin
            next.st = S_LINK_RST;
        end

        if (!pwr_ok)
        begin
            next = '0;
            next.speed = SPEED_RST;
            next.topo = TOPO_RST;
        end

        // outputs follow the step so nothing leads link-up
        next.osc_en = (next.st != S_OFF);
        next.term_cal = (next.st == S_TERM);
        next.beacon = (next.st == S_BEACON) ? next.port_sel : 2'h0;
        next.phy_en = (next.st > S_BEACON) ? next.port_sel : 2'h0;
        next.hs_req = (next.st == S_HS);
        next.cancel_cal = (next.st == S_CANCEL);
        next.eq_cal = (next.st == S_EQ);
        next.chan_en = (next.st == S_LOCK);
        next.lock = (next.st == S_LOCK);
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            cur <= '0;
            cur.speed <= SPEED_RST;
            cur.topo <= TOPO_RST;
        end
        else
        begin
            cur <= next;
        end
    end

    assign REG_RDATA = cur.rdata;
    assign REG_RVALID = cur.rvalid;
    assign OSC_EN = cur.osc_en;
    assign TERM_CAL = cur.term_cal;
    assign BEACON = cur.beacon;
    assign PHY_EN = cur.phy_en;
    assign HANDSHAKE_REQ = cur.hs_req;
    assign CANCEL_CAL = cur.cancel_cal;
    assign EQ_CAL = cur.eq_cal;
    assign CHAN_EN = cur.chan_en;
    assign LOCK = cur.lock;
    assign TX_RATE = cur.act_tx;
    assign RX_RATE = cur.act_rx;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_pdn_off;
        @(posedge CLK) disable iff (!RST_B)
        !pwr_ok |=> (cur.st == S_OFF) && !OSC_EN;
    endproperty
    a_pdn_off: assert property (p_pdn_off)
        else $error("not powered down with pin or supply low");

    property p_term_after_osc;
        @(posedge CLK) disable iff (!RST_B)
        $rose(TERM_CAL) |-> $past(cur.st) == S_OSC && OSC_EN;
    endproperty
    a_term_after_osc: assert property (p_term_after_osc)
        else $error("termination calibration out of order");

    property p_hs_after_beacon;
        @(posedge CLK) disable iff (!RST_B)
        $rose(HANDSHAKE_REQ) |-> $past(BEACON) != 2'h0;
    endproperty
    a_hs_after_beacon: assert property (p_hs_after_beacon)
        else $error("handshake without beacon");

    property p_eq_after_cancel;
        @(posedge CLK) disable iff (!RST_B)
        $rose(EQ_CAL) |-> $past(CANCEL_CAL) && $past(PHY_STAT.cancel_done);
    endproperty
    a_eq_after_cancel: assert property (p_eq_after_cancel)
        else $error("equalizer before canceller");

    property p_lock_pair;
        @(posedge CLK) disable iff (!RST_B)
        LOCK |-> CHAN_EN && cur.st == S_LOCK && !BEACON[0] && !BEACON[1];
    endproperty
    a_lock_pair: assert property (p_lock_pair)
        else $error("lock without channels or outside link-up");

    property p_port_a_restart;
        @(posedge CLK) disable iff (!RST_B)
        wr_topo && REG_REQ.wdata == 8'h21 && pwr_ok
        |=> cur.st == S_LINK_RST && cur.topo == 8'h21
        ##1 !cur.topo[RESTART_BIT] || $past(wr_topo);
    endproperty
    a_port_a_restart: assert property (p_port_a_restart)
        else $error("port select write did not restart");

    property p_auto_ignores_cfg;
        @(posedge CLK) disable iff (!RST_B)
        cur.st == S_LINK_RST && cur.topo[AUTO_BIT] && pwr_ok && !wr_topo
        |=> cur.port_sel == PORT_BOTH && cur.act_auto;
    endproperty
    a_auto_ignores_cfg: assert property (p_auto_ignores_cfg)
        else $error("auto mode used the topology field");

    property p_first_port;
        @(posedge CLK) disable iff (!RST_B)
        cur.st == S_BEACON && cur.act_auto && seen == PORT_B
        |=> cur.st != S_HS || cur.port_sel == PORT_B;
    endproperty
    a_first_port: assert property (p_first_port)
        else $error("auto mode chose the wrong port");

    property p_read_answer;
        @(posedge CLK) disable iff (!RST_B)
        REG_REQ.rd && access && REG_REQ.addr == SPEED_ADDR && pwr_ok
        |=> REG_RVALID && REG_RDATA == $past(cur.speed);
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("register read gave no answer");
endmodule : link_sequencer

// ==== pkg/link_seq_pkg.sv ====
// constants, codes and carriers of the serial link setup sequencer
// assumes a 25 MHz reference clock and an 8-bit local register port
package link_seq_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_KHZ = 25000;
    localparam int OSC_START_US = 1000;
    localparam int OSC_START_CYC = (OSC_START_US * CLK_KHZ + 999) / 1000;
    localparam int TERM_CAL_US = 100;
    localparam int TERM_CAL_CYC = (TERM_CAL_US * CLK_KHZ + 999) / 1000;
    localparam int LOCK_LIMIT_MS = 50;
    localparam int LOCK_LIMIT_CYC = LOCK_LIMIT_MS * CLK_KHZ;
    localparam int CNT_W = 21;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [15:0] SPEED_ADDR = 16'h0001;
    localparam logic [15:0] TOPO_ADDR = 16'h0010;
    localparam logic [15:0] STATUS_ADDR = 16'h0013;
    localparam int TX_RATE_LSB = 2;
    localparam int RX_RATE_LSB = 0;
    localparam int CFG_LSB = 0;
    localparam int AUTO_BIT = 4;
    localparam int RESTART_BIT = 5;
    localparam int LOCK_BIT = 3;
    localparam int STEP_LSB = 4;
    localparam logic [7:0] SPEED_RST = 8'h08;
    localparam logic [7:0] TOPO_RST = 8'h10;

    // ----------------------------------------
    // codes
    // ----------------------------------------
    localparam logic [1:0] RATE_6G = 2'h2;
    localparam logic [1:0] RATE_3G = 2'h1;
    localparam logic [1:0] RATE_REV = 2'h0;
    localparam logic [1:0] TOPO_DUAL = 2'h0;
    localparam logic [1:0] TOPO_A = 2'h1;
    localparam logic [1:0] TOPO_B = 2'h2;
    localparam logic [1:0] TOPO_SPLIT = 2'h3;
    localparam logic [1:0] PORT_A = 2'h1;
    localparam logic [1:0] PORT_B = 2'h2;
    localparam logic [1:0] PORT_BOTH = 2'h3;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        S_OFF, S_OSC, S_TERM, S_STRAP, S_LINK_RST,
        S_BEACON, S_HS, S_CANCEL, S_EQ, S_LOCK
    } seq_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [1:0] beacon_seen;
        logic hs_done;
        logic cancel_done;
        logic eq_done;
    } phy_stat_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] q;
    } sync_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic done;
    } timer_state_t;

    typedef struct packed {
        seq_state_t st;
        logic [7:0] speed;
        logic [7:0] topo;
        logic [1:0] act_tx;
        logic [1:0] act_rx;
        logic [1:0] port_sel;
        logic act_auto;
        logic [CNT_W-1:0] deadline;
        logic [7:0] rdata;
        logic rvalid;
        logic osc_en;
        logic term_cal;
        logic [1:0] beacon;
        logic [1:0] phy_en;
        logic hs_req;
        logic cancel_cal;
        logic eq_cal;
        logic chan_en;
        logic lock;
    } seq_t;

endpackage : link_seq_pkg

// ==== hdl/pin_sync.sv ====
// three-stage synchroniser for the asynchronous pins
// assumes pins are quasi-static; a change counts once stages agree
`timescale 1ns/10ps
module pin_sync
    import link_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] pin,
    output logic [3:0] q
);
    sync_state_t cur;
    sync_state_t next;

    always_comb
    begin
        next = cur;
        next.s1 = pin;
        next.s2 = cur.s1;
        next.s3 = cur.s2;
        for (int i = 0; i < 4; i++)
        begin
            if (cur.s2[i] == cur.s3[i])
            begin
                next.q[i] = cur.s3[i];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next;
        end
    end

    assign q = cur.q;
endmodule : pin_sync

// ==== hdl/step_timer.sv ====
// down counter timing the power-up steps
// assumes start is a one-cycle pulse; done pulses when the count ends
`timescale 1ns/10ps
module step_timer
    import link_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [CNT_W-1:0] load,
    output logic done
);
    timer_state_t cur;
    timer_state_t next;

    always_comb
    begin
        next = cur;
        next.done = 1'b0;
        if (start)
        begin
            next.cnt = load;
        end
        else if (cur.cnt != '0)
        begin
            next.cnt = cur.cnt - 1'b1;
            next.done = (cur.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next;
        end
    end

    assign done = cur.done;
endmodule : step_timer

// ==== tb/phy_partner.sv ====
// far-side phy model: reports attached ports as beacons seen, answers steps
// assumes step requests are levels on clk; answers come dly cycles late
`timescale 1ns/10ps
module phy_partner
    import link_seq_pkg::*;
(
    input wire logic clk,
    input wire logic [1:0] conn,
    input wire logic [2:0] dly,
    input wire logic hs_req,
    input wire logic cancel_cal,
    input wire logic eq_cal,
    output phy_stat_t stat
);
    // ----------------------------------------
    // step answers
    // ----------------------------------------
    logic [2:0] cnt;
    logic busy;
    logic fire;

    assign busy = hs_req | cancel_cal | eq_cal;
    // a pending answer blocks a repeat while the step output still stands
    assign fire = busy && cnt == dly
        && !(stat.hs_done | stat.cancel_done | stat.eq_done);

    always_ff @(posedge clk)
    begin
        stat.beacon_seen <= conn;
        stat.hs_done <= fire & hs_req;
        stat.cancel_done <= fire & cancel_cal;
        stat.eq_done <= fire & eq_cal;
        cnt <= (fire || !busy) ? 3'h0 : cnt + 3'h1;
    end
endmodule : phy_partner

// ==== tb/serial_link_setup_sequencer_bench.sv ====
// self-checking bench of the link sequencer with a far-side phy model
// assumes shortened oscillator and lock-limit counts; 25 MHz clock
`timescale 1ns/10ps
module serial_link_setup_sequencer_bench
    import link_seq_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic pwr_n = 1'b0;
    logic sup = 1'b0;
    logic [1:0] strap = 2'h0;
    logic [1:0] conn = 2'h0;
    logic [2:0] dly = 3'h0;
    reg_req_t req = '0;
    logic [7:0] rdata;
    logic rvalid, osc_en, term_cal, hs_req, cancel_cal, eq_cal, chan_en, lock;
    logic [1:0] beacon, phy_en, tx_rate, rx_rate;
    phy_stat_t stat;
    int miscompares = 0;
    int comparisons = 0;
    int seed = 61996;
    logic [7:0] exp_q[$];

    always #20 clk = ~clk;

    link_sequencer #(.OSC_START_CYCLES(20), .LOCK_LIMIT_CYCLES(200))
    i_link_sequencer (.CLK(clk), .RST_B(rst_b), .POWER_DOWN_N_PIN(pwr_n),
        .SUPPLY_OK(sup), .STRAP(strap), .REG_REQ(req), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .PHY_STAT(stat), .OSC_EN(osc_en),
        .TERM_CAL(term_cal), .BEACON(beacon), .PHY_EN(phy_en),
        .HANDSHAKE_REQ(hs_req), .CANCEL_CAL(cancel_cal), .EQ_CAL(eq_cal),
        .CHAN_EN(chan_en), .LOCK(lock), .TX_RATE(tx_rate),
        .RX_RATE(rx_rate));

    phy_partner i_phy_partner (.clk(clk), .conn(conn), .dly(dly),
        .hs_req(hs_req), .cancel_cal(cancel_cal), .eq_cal(eq_cal),
        .stat(stat));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask : wr

    // expectation is noted before the strobe; the monitor pops it
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
    endtask : rd

    function automatic logic cond(input int w);
        case (w)
            0: return term_cal;
            1: return |beacon;
            default: return lock;
        endcase
    endfunction : cond

    // bounded wait; the caller judges the outcome
    task automatic wait_for(input int w, input int lim);
        int i;
        i = 0;
        while (cond(w) !== 1'b1 && i < lim)
        begin
            @(posedge clk);
            i++;
        end
    endtask : wait_for

    task automatic relink(input logic [7:0] code, input logic [1:0] port);
        wr(TOPO_ADDR, code);
        cyc(2);
        check({7'h0, lock}, 8'h00);
        check({7'h0, chan_en}, 8'h00);
        wait_for(2, 800);
        check({7'h0, lock}, 8'h01);
        check({6'h0, phy_en}, {6'h0, port});
    endtask : relink

    always @(posedge clk)
    begin
        if (rvalid === 1'b1)
        begin
            if (exp_q.size() > 0)
                check(rdata, exp_q.pop_front());
            else
                check(rdata, 8'hXX);
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        cyc(2);
        rst_b <= 1'b1;
        // powered down: the register port gives no answer at all
        req <= {1'b0, 1'b1, SPEED_ADDR, 8'h00};
        cyc(1);
        req <= '0;
        cyc(1);
        check({7'h0, rvalid}, 8'h00);
        pwr_n <= 1'b1;
        cyc(20);
        check({7'h0, osc_en}, 8'h00);
        strap <= 2'($random(seed));
        dly <= 3'($random(seed));
        sup <= 1'b1;
        wait_for(0, 200);
        check({7'h0, osc_en}, 8'h01);
        wait_for(1, 4000);
        check({7'h0, term_cal}, 8'h00);
        check({6'h0, beacon}, 8'h03);
        rd(SPEED_ADDR, {4'h0, strap, RATE_REV});
        rd(TOPO_ADDR, TOPO_RST);
        // nobody attached yet: no handshake may start
        cyc(10);
        check({7'h0, hs_req}, 8'h00);
        conn <= PORT_B;
        wait_for(2, 800);
        check({6'h0, phy_en}, {6'h0, PORT_B});
        check({7'h0, chan_en}, 8'h01);
        check({6'h0, cancel_cal, eq_cal}, 8'h00);
        check({6'h0, tx_rate}, {6'h0, strap});
        rd(STATUS_ADDR, 8'h98);
        wr(STATUS_ADDR, 8'h00);
        rd(STATUS_ADDR, 8'h98);
        rd(16'h0055, 8'h00);
        conn <= PORT_BOTH;
        for (int k = 0; k < 2; k++)
        begin
            wr(SPEED_ADDR,
                {4'h0, (k == 1) ? RATE_6G : RATE_3G, RATE_REV});
            relink(8'h21, PORT_A);
            check({6'h0, tx_rate}, (k == 1) ? 8'h02 : 8'h01);
            check({6'h0, rx_rate}, {6'h0, RATE_REV});
        end
        rd(TOPO_ADDR, 8'h01);
        rd(SPEED_ADDR, 8'h08);
        relink(8'h22, PORT_B);
        relink(8'h30, PORT_A);
        relink(8'h33, PORT_A);
        rd(TOPO_ADDR, 8'h13);
        relink(8'h23, PORT_BOTH);
        // power-down in mid-run wipes link and registers
        pwr_n <= 1'b0;
        cyc(8);
        check({7'h0, lock}, 8'h00);
        check({7'h0, osc_en}, 8'h00);
        pwr_n <= 1'b1;
        wait_for(1, 4000);
        rd(TOPO_ADDR, TOPO_RST);
        cyc(4);
        check(8'(exp_q.size()), 8'h00);
        end_of_test();
    end

    // about 20000 cycles, several times the expected run
    initial
    begin
        #800000;
        miscompares++;
        end_of_test();
    end
endmodule : serial_link_setup_sequencer_bench
